// file: logic/ebs_top.sv
// external bus strobe interface: strobes, hold, dram and memory map
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - separate strobes: even low, odd high
// - read strobe low marks every read
// - combined: write strobe plus odd high enable
// - software input selects the strobe scheme
// - hold request low keeps hold, acknowledge low
// - address latch enable captures multiplexed address
// - dram write low for dram writes only
// - column strobes by byte lane, both for word
// - column strobe falling edge latches column
// - row strobe falling edge latches row
// - full 24-bit, 16 megabyte linear space
// - up to 0003ff is peripheral register area
// - internal ram starts at 000400
// - fixed vectors from ffffdc upward
// - special page table fffe00 to ffffdb
// - eight high address pins, top inverted
// - four active-low space selects per cycle
// - dram row then column on same lines
module ebs_top (
  // clock and reset
  input  wire logic        i_clk_sys,
  input  wire logic        i_nrst,
  // configuration
  input  wire logic        i_combined_scheme,
  input  wire logic [23:0] i_ram_hi,
  input  wire logic [23:0] i_dram_lo,
  input  wire logic [23:0] i_dram_hi,
  input  wire logic [95:0] i_space_base,
  // access request
  input  wire logic        i_req_valid,
  output logic             o_req_ready,
  input  wire logic        i_req_write,
  input  wire logic [1:0]  i_req_bytes,
  input  wire logic [23:0] i_req_addr,
  input  wire logic [15:0] i_req_wdata,
  output logic             o_rsp_valid,
  output logic [15:0]      o_rsp_rdata,
  output logic [5:0]       o_rsp_region,
  // hold handshake
  input  wire logic        i_hold_request_n,
  output logic             o_hold_acknowledge_n,
  // multiplexed address/data
  input  wire logic [15:0] i_ad,
  output logic [15:0]      o_ad,
  output logic [15:0]      o_ad_oe,
  output logic [6:0]       o_high_address,
  output logic             o_top_address_bit_inverted,
  output logic             o_high_addr_oe,
  // strobes
  output logic             o_ale,
  output logic             o_read_strobe_n,
  output logic             o_low_byte_write_strobe_n,
  output logic             o_high_byte_write_strobe_n,
  output logic             o_strobe_oe,
  output logic [3:0]       o_space_selects_n,
  // dram
  output logic [12:0]      o_dram_address_lines,
  output logic             o_dram_write_strobe_n,
  output logic             o_column_strobe_low_n,
  output logic             o_column_strobe_high_n,
  output logic             o_row_strobe_n
);
  typedef struct packed {
    ebs_pkg::ebs_state_t st;
    logic [3:0]          cnt;
    logic                wr;
    logic [1:0]          be;
    logic [23:0]         addr;
    logic [15:0]         wdata;
    logic [5:0]          region;
    logic [3:0]          cs;
    logic                comb;
    logic                ale;
    logic                rd_n;
    logic                lo_n;
    logic                hi_n;
    logic [15:0]         ad;
    logic [15:0]         ad_oe;
    logic                drv;
    logic [12:0]         ma;
    logic                dw_n;
    logic                column_strobe_low_n;
    logic                column_strobe_high_n;
    logic                ras_n;
    logic                hold_acknowledge_n;
    logic                rsp_v;
    logic [15:0]         rdata;
  } ebs_core_t;

  ebs_core_t           r;
  ebs_core_t           next_r;
  ebs_pkg::ebs_region_t dec_region;
  logic [3:0]          dec_hit;
  logic [3:0][23:0]    space_base;

  assign space_base = i_space_base;

  ebs_decode u_decode (
    .i_addr       (i_req_addr),
    .i_ram_hi     (i_ram_hi),
    .i_dram_lo    (i_dram_lo),
    .i_dram_hi    (i_dram_hi),
    .i_space_base (space_base),
    .o_region     (dec_region),
    .o_space_hit  (dec_hit)
  );

  // byte lanes: a single-byte access uses the lane of address bit 0
  function automatic logic [1:0] lanes(input logic [1:0] bytes,
                                       input logic       a0);
    if (bytes == 2'h2) begin
      lanes = 2'h3;
    end else if (a0) begin
      lanes = 2'h2;
    end else begin
      lanes = 2'h1;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_r       = r;
    next_r.rsp_v = 1'b0;
    case (r.st)
      ebs_pkg::EBS_IDLE: begin
        next_r.drv = 1'b1;
        if (!i_hold_request_n) begin
          next_r.st     = ebs_pkg::EBS_HOLD;
          next_r.hold_acknowledge_n = 1'b0;
          next_r.drv    = 1'b0;
          next_r.ad_oe  = 16'h0000;
        end else if (i_req_valid) begin
          next_r.wr     = i_req_write;
          next_r.be     = lanes(i_req_bytes, i_req_addr[0]);
          next_r.addr   = i_req_addr;
          next_r.wdata  = i_req_wdata;
          next_r.region = dec_region;
          next_r.comb   = i_combined_scheme;
          next_r.cnt    = 4'h0;
          if (dec_region == ebs_pkg::EBS_REG_DRAM) begin
            next_r.st = ebs_pkg::EBS_ROW;
            next_r.ma = i_req_addr[23:11];
          end else begin
            next_r.st    = ebs_pkg::EBS_ADDR;
            next_r.cs    = ~dec_hit;
            next_r.ale   = 1'b1;
            next_r.ad    = i_req_addr[15:0];
            next_r.ad_oe = 16'hffff;
          end
        end
      end
      ebs_pkg::EBS_ADDR: begin
        next_r.ale = 1'b0;
        next_r.st  = ebs_pkg::EBS_STROBE;
        if (r.wr) begin
          next_r.ad = r.wdata;
          if (r.comb) begin
            next_r.lo_n = 1'b0;
            next_r.hi_n = ~r.be[1];
          end else begin
            next_r.lo_n = ~r.be[0];
            next_r.hi_n = ~r.be[1];
          end
        end else begin
          next_r.ad_oe = 16'h0000;
          next_r.rd_n  = 1'b0;
          next_r.hi_n  = r.comb ? ~r.be[1] : 1'b1;
        end
      end
      ebs_pkg::EBS_STROBE: begin
        next_r.cnt = r.cnt + 4'h1;
        if (r.cnt == ebs_pkg::STROBE_CYC - 4'h1) begin
          next_r.rdata = i_ad;
          next_r.rd_n  = 1'b1;
          next_r.lo_n  = 1'b1;
          next_r.hi_n  = 1'b1;
          next_r.column_strobe_low_n = 1'b1;
          next_r.column_strobe_high_n = 1'b1;
          next_r.ras_n  = 1'b1;
          next_r.dw_n   = 1'b1;
          next_r.st    = ebs_pkg::EBS_END;
        end
      end
      ebs_pkg::EBS_ROW: begin
        next_r.ras_n = 1'b0;
        next_r.dw_n  = ~r.wr;
        next_r.st    = ebs_pkg::EBS_COL;
        if (r.wr) begin
          next_r.ad    = r.wdata;
          next_r.ad_oe = 16'hffff;
        end
      end
      ebs_pkg::EBS_COL: begin
        next_r.ma     = {2'h0, r.addr[10:0]};
        next_r.rd_n   = r.wr;
        next_r.column_strobe_low_n = ~r.be[0];
        next_r.column_strobe_high_n = ~r.be[1];
        next_r.cnt    = 4'h0;
        next_r.st     = ebs_pkg::EBS_STROBE;
      end
      ebs_pkg::EBS_END: begin
        next_r.cs    = 4'hf;
        next_r.ad_oe = 16'h0000;
        next_r.rsp_v = 1'b1;
        next_r.st    = ebs_pkg::EBS_IDLE;
      end
      ebs_pkg::EBS_HOLD: begin
        if (i_hold_request_n) begin
          next_r.hold_acknowledge_n = 1'b1;
          next_r.drv    = 1'b1;
          next_r.st     = ebs_pkg::EBS_IDLE;
        end
      end
      default: begin
        next_r.st = ebs_pkg::EBS_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_nrst) begin
      r        <= '0;
      r.st     <= ebs_pkg::EBS_IDLE;
      r.cs     <= 4'hf;
      r.rd_n   <= 1'b1;
      r.lo_n   <= 1'b1;
      r.hi_n   <= 1'b1;
      r.dw_n   <= 1'b1;
      r.column_strobe_low_n <= 1'b1;
      r.column_strobe_high_n <= 1'b1;
      r.ras_n  <= 1'b1;
      r.hold_acknowledge_n <= 1'b1;
      r.drv    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  assign o_req_ready                = (r.st == ebs_pkg::EBS_IDLE) &&
                                      i_hold_request_n;
  assign o_rsp_valid                = r.rsp_v;
  assign o_rsp_rdata                = r.rdata;
  assign o_rsp_region               = r.region;
  assign o_hold_acknowledge_n       = r.hold_acknowledge_n;
  assign o_ad                       = r.ad;
  assign o_ad_oe                    = r.ad_oe;
  assign o_high_address             = r.addr[22:16];
  assign o_top_address_bit_inverted = ~r.addr[23];
  assign o_high_addr_oe             = r.drv;
  assign o_strobe_oe                = r.drv;
  assign o_ale                      = r.ale;
  assign o_read_strobe_n            = r.rd_n;
  assign o_low_byte_write_strobe_n  = r.lo_n;
  assign o_high_byte_write_strobe_n = r.hi_n;
  assign o_space_selects_n          = r.cs;
  assign o_dram_address_lines       = r.ma;
  assign o_dram_write_strobe_n      = r.dw_n;
  assign o_column_strobe_low_n      = r.column_strobe_low_n;
  assign o_column_strobe_high_n     = r.column_strobe_high_n;
  assign o_row_strobe_n             = r.ras_n;
endmodule // ebs_top
`default_nettype wire

// file: logic/ebs_pkg.sv
// package: constants and types for the external bus strobe interface
`default_nettype none
package ebs_pkg;
  localparam int ADDR_W = 24;
  localparam int DATA_W = 16;
  localparam int DRAM_AW = 13;
  // memory map boundaries
  localparam logic [23:0] PERIPH_LO   = 24'h000000;
  localparam logic [23:0] PERIPH_HI   = 24'h0003ff;
  localparam logic [23:0] RAM_LO      = 24'h000400;
  localparam logic [23:0] SPAGE_LO    = 24'hfffe00;
  localparam logic [23:0] SPAGE_HI    = 24'hfffedb + 24'h000100;
  localparam logic [23:0] FIXVEC_LO   = 24'hffffdc;
  // defaults for configurable limits
  localparam logic [23:0] RAM_HI_DEF  = 24'h002bff;
  localparam logic [23:0] DRAM_LO_DEF = 24'h400000;
  localparam logic [23:0] DRAM_HI_DEF = 24'h7fffff;
  // region codes
  typedef enum logic [5:0] {
    EBS_REG_PERIPH = 6'h01,
    EBS_REG_RAM    = 6'h02,
    EBS_REG_EXT    = 6'h04,
    EBS_REG_DRAM   = 6'h08,
    EBS_REG_SPAGE  = 6'h10,
    EBS_REG_FIXVEC = 6'h20
  } ebs_region_t;
  // bus cycle states
  typedef enum logic [6:0] {
    EBS_IDLE   = 7'h01,
    EBS_ADDR   = 7'h02,
    EBS_STROBE = 7'h04,
    EBS_END    = 7'h08,
    EBS_ROW    = 7'h10,
    EBS_COL    = 7'h20,
    EBS_HOLD   = 7'h40
  } ebs_state_t;
  // strobe widths in cycles
  localparam logic [3:0] STROBE_CYC = 4'h2;
endpackage : ebs_pkg
`default_nettype wire

// file: logic/ebs_decode.sv
// memory map decoder for the external bus strobe interface
`timescale 1ns/1ps
`default_nettype none
module ebs_decode (
  // address in
  input  wire logic [23:0]         i_addr,
  input  wire logic [23:0]         i_ram_hi,
  input  wire logic [23:0]         i_dram_lo,
  input  wire logic [23:0]         i_dram_hi,
  input  wire logic [3:0][23:0]    i_space_base,
  // decode out
  output ebs_pkg::ebs_region_t     o_region,
  output logic [3:0]               o_space_hit
);
  always_comb begin
    if (i_addr <= ebs_pkg::PERIPH_HI) begin
      o_region = ebs_pkg::EBS_REG_PERIPH;
    end else if (i_addr <= i_ram_hi) begin
      o_region = ebs_pkg::EBS_REG_RAM;
    end else if (i_addr >= ebs_pkg::FIXVEC_LO) begin
      o_region = ebs_pkg::EBS_REG_FIXVEC;
    end else if (i_addr >= ebs_pkg::SPAGE_LO) begin
      o_region = ebs_pkg::EBS_REG_SPAGE;
    end else if (i_addr >= i_dram_lo && i_addr <= i_dram_hi) begin
      o_region = ebs_pkg::EBS_REG_DRAM;
    end else begin
      o_region = ebs_pkg::EBS_REG_EXT;
    end
  end

  // space selects 0 to 2 cover from their base up to the next base, select 3 from its base to the top
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      o_space_hit[i] = (i_addr >= i_space_base[i]) &&
                       ((i == 3) || (i_addr < i_space_base[(i + 1) % 4]));
    end
  end
endmodule // ebs_decode
`default_nettype wire

// file: test/ebs_props.sv
// checker: hold, strobe and address pin properties
`timescale 1ns/1ps
`default_nettype none
module ebs_props (
  // clock, reset, request
  input wire logic        i_clk_sys,
  input wire logic        i_nrst,
  input wire logic        i_req_valid,
  input wire logic        o_req_ready,
  input wire logic [23:0] i_req_addr,
  input wire logic        o_rsp_valid,
  // hold
  input wire logic        i_hold_request_n,
  input wire logic        o_hold_acknowledge_n,
  input wire logic [15:0] o_ad_oe,
  input wire logic        o_high_addr_oe,
  input wire logic        o_strobe_oe,
  // pins
  input wire logic [6:0]  o_high_address,
  input wire logic        o_top_address_bit_inverted,
  input wire logic        o_ale,
  input wire logic        o_read_strobe_n,
  input wire logic        o_low_byte_write_strobe_n,
  input wire logic        o_dram_write_strobe_n,
  input wire logic        o_column_strobe_low_n,
  input wire logic        o_row_strobe_n
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_nrst);
  wire take = i_req_valid && o_req_ready;
  ////////////////////////////////////////////////////////////////////////////
  chk_hold_stays: assert property (
    !i_hold_request_n && !o_hold_acknowledge_n |=> !o_hold_acknowledge_n)
    else $error("hold left while requested");
  chk_hold_release: assert property (
    !o_hold_acknowledge_n |-> !o_strobe_oe && !o_high_addr_oe && !o_ad_oe)
    else $error("outputs driven in hold");
  chk_hold_refuse: assert property (
    !i_hold_request_n |-> !o_req_ready)
    else $error("request taken during hold");
  chk_rsp_latency: assert property (
    take |-> ##[5:6] o_rsp_valid)
    else $error("no response in time");
  chk_ale_pulse: assert property (
    $rose(o_ale) |=> !o_ale)
    else $error("latch enable too long");
  chk_high_addr: assert property (
    take |=> o_top_address_bit_inverted == !$past(i_req_addr[23]) &&
      o_high_address == $past(i_req_addr[22:16]))
    else $error("high address pins wrong");
  chk_read_only: assert property (
    !o_read_strobe_n |-> o_low_byte_write_strobe_n ##[1:3] o_read_strobe_n)
    else $error("read strobe with write strobe");
  chk_cas_row: assert property (
    !o_column_strobe_low_n |-> !o_row_strobe_n)
    else $error("column strobe without row");
  chk_dw_row: assert property (
    $fell(o_dram_write_strobe_n) |-> !o_row_strobe_n)
    else $error("dram write outside row");
  cover property (!o_hold_acknowledge_n);
  cover property ($fell(o_column_strobe_low_n));
  cover property (take ##1 o_ale);
endmodule // ebs_props
bind ebs_top ebs_props i_ebs_props (.*);
`default_nettype wire

// file: test/ebs_mem_model.sv
// partner: external memory answering on the multiplexed bus
`timescale 1ns/1ps
`default_nettype none
module ebs_mem_model (
  // strobes and bus from the device
  input  wire logic        i_clk_sys,
  input  wire logic        i_comb,
  input  wire logic        i_ale,
  input  wire logic        i_rd_n,
  input  wire logic        i_wrl_n,
  input  wire logic        i_wrh_n,
  input  wire logic [15:0] i_ad,
  // read data
  output logic      [15:0] o_ad
);
  logic [15:0] mem [256];
  logic [15:0] la = 16'h0000;
  logic [15:0] last = 16'h0000;
  logic        rd_d = 1'b0;
  wire lo = i_comb ? !i_wrl_n && !la[0] : !i_wrl_n;
  wire hi = i_comb ? !i_wrl_n && !i_wrh_n : !i_wrh_n;
  // released lines toggle so stale data never looks valid
  assign o_ad = (!i_rd_n || rd_d) ? mem[la[8:1]] : ~last;
  initial foreach (mem[i]) mem[i] = 16'h0000;
  always @(posedge i_clk_sys) begin
    last <= o_ad;
    rd_d <= !i_rd_n;
    if (i_ale) la <= i_ad;
    if (lo) mem[la[8:1]][7:0] <= i_ad[7:0];
    if (hi) mem[la[8:1]][15:8] <= i_ad[15:8];
  end
endmodule // ebs_mem_model
`default_nettype wire

// file: test/ebs_top_tb.sv
// testbench: strobe schemes, dram, memory map and hold
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %0t got %0h exp %0h", $time, g, e); end end
module ebs_top_tb;
  logic        clk = 1'b0, nrst = 1'b0, comb = 1'b0, valid = 1'b0;
  logic        wr = 1'b0, hold_n = 1'b1;
  logic [1:0]  bytes = 2'h0;
  logic [23:0] addr = 24'h000000;
  logic [15:0] wdata = 16'h0000, dad, dad_oe, mad, rdata;
  logic        ready, rsp_v, hold_acknowledge_n, top_inv, ale, rd_n, wrl_n, wrh_n;
  logic        dw_n, column_strobe_low_n, column_strobe_high_n, ras_n;
  logic [3:0]  cs_n, cs_e;
  logic [12:0] ma_l;
  logic [6:0]  hi_a;
  logic [5:0]  region;
  int          num_errors = 0, compares = 0;
  int          rm[int];
  wire logic [15:0] bus = (dad & dad_oe) | (mad & ~dad_oe);
  ////////////////////////////////////////////////////////////////////////////
  ebs_top i_ebs_top (.i_clk_sys(clk), .i_nrst(nrst),
    .i_combined_scheme(comb), .i_ram_hi(ebs_pkg::RAM_HI_DEF),
    .i_dram_lo(ebs_pkg::DRAM_LO_DEF), .i_dram_hi(ebs_pkg::DRAM_HI_DEF),
    .i_space_base(96'h800000_400000_010000_000000),
    .i_req_valid(valid), .o_req_ready(ready), .i_req_write(wr),
    .i_req_bytes(bytes), .i_req_addr(addr), .i_req_wdata(wdata),
    .o_rsp_valid(rsp_v), .o_rsp_rdata(rdata), .o_rsp_region(region),
    .i_hold_request_n(hold_n), .o_hold_acknowledge_n(hold_acknowledge_n),
    .i_ad(bus), .o_ad(dad), .o_ad_oe(dad_oe), .o_high_address(hi_a),
    .o_top_address_bit_inverted(top_inv), .o_high_addr_oe(),
    .o_ale(ale), .o_read_strobe_n(rd_n), .o_low_byte_write_strobe_n(wrl_n),
    .o_high_byte_write_strobe_n(wrh_n), .o_strobe_oe(),
    .o_space_selects_n(cs_n), .o_dram_address_lines(ma_l),
    .o_dram_write_strobe_n(dw_n), .o_column_strobe_low_n(column_strobe_low_n),
    .o_column_strobe_high_n(column_strobe_high_n), .o_row_strobe_n(ras_n));
  ebs_mem_model i_ebs_mem_model (.i_clk_sys(clk), .i_comb(comb),
    .i_ale(ale), .i_rd_n(rd_n), .i_wrl_n(wrl_n), .i_wrh_n(wrh_n),
    .i_ad(bus), .o_ad(mad));
  initial forever #2.5 clk = ~clk;
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [5:0] rgn(input logic [23:0] a);
    if (a <= ebs_pkg::PERIPH_HI) return 6'h01;
    if (a <= ebs_pkg::RAM_HI_DEF) return 6'h02;
    if (a >= ebs_pkg::FIXVEC_LO) return 6'h20;
    if (a >= ebs_pkg::SPAGE_LO) return 6'h10;
    if (a >= ebs_pkg::DRAM_LO_DEF && a <= ebs_pkg::DRAM_HI_DEF) return 6'h08;
    return 6'h04;
  endfunction
  task automatic tick(inout int n);
    @(posedge clk);
    #1 n++;
  endtask
  task automatic acc(input logic w, input logic [1:0] b,
                     input logic [23:0] a, input logic [15:0] d);
    int n, v;
    logic lo, hi;
    logic [5:0] rg;
    lo = b == 2'h2 || !a[0];
    hi = b == 2'h2 || a[0];
    rg = rgn(a);
    // spaces 0 to 2 run from their base up to the next base, space 3 to the top
    cs_e = a >= 24'h800000 ? 4'h8 : a >= 24'h400000 ? 4'h4 :
           a >= 24'h010000 ? 4'h2 : 4'h1;
    {valid, wr, bytes, addr, wdata} = {1'b1, w, b, a, d};
    n = 0;
    while (!ready && n < 50) tick(n);
    tick(n);
    valid = 1'b0;
    n = 0;
    if (rg == 6'h08) begin
      while (ras_n && n < 20) tick(n);
      `CHK(dw_n, !w)
      `CHK(ma_l, a[23:11])
      while (column_strobe_low_n && column_strobe_high_n && n < 20) tick(n);
      `CHK({column_strobe_low_n, column_strobe_high_n}, {!lo, !hi})
      `CHK(ma_l, {2'h0, a[10:0]})
    end else if (rg == 6'h04) begin
      while (rd_n && wrl_n && wrh_n && n < 20) tick(n);
      `CHK({rd_n, wrl_n, wrh_n}, {w, comb ? !w : !(w && lo), comb ? !hi : !(w && hi)})
      `CHK({top_inv, hi_a}, {!a[23], a[22:16]})
      `CHK(cs_n, ~cs_e)
    end
    while (!rsp_v && n < 40) tick(n);
    `CHK({rsp_v, region}, {1'b1, rg})
    v = rm.exists(a[8:1]) ? rm[a[8:1]] : 0;
    if (!w && b == 2'h2 && rg == 6'h04) `CHK(rdata, v[15:0])
    if (lo) v[7:0] = d[7:0];
    if (hi) v[15:8] = d[15:8];
    if (w && rg == 6'h04) rm[a[8:1]] = v;
  endtask
  task automatic end_sim;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [23:0] a;
    logic [15:0] d;
    logic [23:0] tbl [11] = '{24'h000000, 24'h0003ff, 24'h000400,
      24'h002bff, 24'h010001, 24'h400000, 24'h7fffff, 24'hfffe00,
      24'hffffdb, 24'hffffdc, 24'hffffff};
    void'($urandom(32'hc7ef));
    repeat (4) @(posedge clk);
    #1 nrst = 1'b1;
    `CHK({hold_acknowledge_n, ale, rd_n, wrl_n, wrh_n}, 5'h17)
    for (int c = 0; c < 2; c++) begin
      comb = c[0];
      for (int i = 0; i < 6; i++) begin
        a = 24'h010000 | 24'($urandom & 32'h1fe);
        d = 16'($urandom);
        acc(1'b1, 2'h2, a, 16'($urandom));
        acc(1'b1, 2'h0, a, {2{d[7:0]}});
        acc(1'b1, 2'h0, a | 24'h000001, {2{d[15:8]}});
        acc(1'b0, 2'h2, a, 16'h0000);
      end
      $display("scheme test %0d done", c);
    end
    foreach (tbl[i]) acc(1'b0, 2'h0, tbl[i], 16'h0000);
    $display("map test done");
    for (int i = 0; i < 4; i++) begin
      a = 24'h400000 | 24'($urandom & 32'h3ffffe);
      acc(1'b1, 2'h2, a, 16'($urandom));
      acc(1'b1, 2'h0, a | 24'h000001, 16'($urandom));
      acc(1'b0, 2'h2, a, 16'h0000);
    end
    $display("dram test done");
    hold_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 `CHK({hold_acknowledge_n, ready}, 2'b00)
    fork
      acc(1'b1, 2'h2, 24'h010100, 16'h5a5a);
      begin
        repeat (6) @(posedge clk);
        #1 hold_n = 1'b1;
      end
    join
    `CHK(hold_acknowledge_n, 1'b1)
    acc(1'b0, 2'h2, 24'h010100, 16'h0000);
    $display("hold test done");
    end_sim;
  end
  // about fifty times the expected run length
  initial begin
    #100000;
    num_errors++;
    end_sim;
  end
endmodule // ebs_top_tb
`default_nettype wire
